// *** rtl/frt_pkg.sv ***
// package of register map, field layout and encodings for the free-running timer
package frt_pkg;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] ADDR_INT_ENABLE = 16'hFF90; // interrupt_enable_reg
	localparam logic [15:0] ADDR_EVENT_FLAGS = 16'hFF91; // event_flags_reg
	localparam logic [15:0] ADDR_COUNTER = 16'hFF92; // counter_value
	localparam logic [15:0] ADDR_COMPARE = 16'hFF94; // compare a or b, by compare_select
	localparam logic [15:0] ADDR_TIMER_CTRL = 16'hFF96; // timer_control_reg
	localparam logic [15:0] ADDR_OUT_CTRL = 16'hFF97; // compare_output_control
	localparam logic [15:0] ADDR_SHARED_A = 16'hFF98; // capture a or rise step
	localparam logic [15:0] ADDR_SHARED_B = 16'hFF9A; // capture b or fall step
	localparam logic [15:0] ADDR_SHARED_C = 16'hFF9C; // capture c or mask span
	localparam logic [15:0] ADDR_CAPTURE_D = 16'hFF9E; // capture_d_value

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_INT_ENABLE = 8'h01;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNTER = 16'h0000;
	localparam logic [15:0] RST_COMPARE = 16'hFFFF;
	localparam logic [15:0] RST_STEP = 16'hFFFF;
	localparam logic [15:0] RST_CAPTURE = 16'h0000;
	localparam logic [7:0] RST_SPAN = 8'h00;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [7:0] IER_FIXED_ONE = 8'h01; // bit 0 always reads one

	// ----------------------------------------------------------------
	// flag bit positions in event_flags_reg
	// ----------------------------------------------------------------
	localparam int FLAG_CAP_A = 7; // capture channel n flag at FLAG_CAP_A - n
	localparam int FLAG_CMP_A = 3;
	localparam int FLAG_CMP_B = 2;
	localparam int FLAG_OVF = 1;
	localparam int FLAG_CLR_A = 0; // clear_on_match_a, plain read/write

	// ----------------------------------------------------------------
	// clock source codes and prescale masks
	// ----------------------------------------------------------------
	localparam logic [1:0] CKS_DIV2 = 2'h0;
	localparam logic [1:0] CKS_DIV8 = 2'h1;
	localparam logic [1:0] CKS_DIV32 = 2'h2;
	localparam logic [1:0] CKS_EXT = 2'h3;
	localparam logic [4:0] MASK_DIV2 = 5'h01;
	localparam logic [4:0] MASK_DIV8 = 5'h07;
	localparam logic [4:0] MASK_DIV32 = 5'h1F;

	// timer_control_reg layout
	typedef struct packed {
		logic [3:0] edge_sel; // [3]=a .. [0]=d, 1 rising, 0 falling
		logic buffer_a_enable;
		logic buffer_b_enable;
		logic clock_select_hi;
		logic clock_select_lo;
	} frt_tcr_type;

	// compare_output_control layout
	typedef struct packed {
		logic capture_d_mask_enable;
		logic auto_add_enable;
		logic capture_select; // 0 capture regs, 1 step and span regs
		logic compare_select; // 0 compare a, 1 compare b
		logic compare_a_pin_enable;
		logic compare_b_pin_enable;
		logic compare_a_pin_level;
		logic compare_b_pin_level;
	} frt_compare_output_control_type;

	// register bus request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} frt_bus_req_type;

	// capture d mask interval state
	typedef enum logic [1:0] {
		FRT_MASK_IDLE = 2'b01,
		FRT_MASK_ACTIVE = 2'b10
	} frt_mask_state_type;

endpackage

// *** rtl/frt_timer.sv ***
// free-running capture/compare timer with register port
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

module frt_timer #(
	parameter int CNT_W = 16, // counter and register width
	parameter int CAP_N = 4 // capture channels
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire frt_pkg::frt_bus_req_type bus_req,
	output logic [15:0] bus_rdata_ff,
	input wire logic count_clock_pin,
	input wire logic [CAP_N-1:0] capture_pins,
	output logic compare_a_pin_ff,
	output logic compare_b_pin_ff,
	output logic [6:0] irq_req_ff
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] int_enable_ff; // interrupt_enable_reg bits 7..1 used
	logic [7:1] flags_ff; // event flags
	logic clear_on_match_a_ff; // event_flags_reg bit 0
	logic [CNT_W-1:0] counter_ff; // counter_value
	logic [CNT_W-1:0] compare_a_ff; // compare_a_value
	logic [CNT_W-1:0] compare_b_ff; // compare_b_value
	logic [CNT_W-1:0] rise_step_ff; // compare_a_rise_step
	logic [CNT_W-1:0] fall_step_ff; // compare_a_fall_step
	logic [7:0] span_ff; // capture_d_mask_span, upper byte fixed zero
	logic [CNT_W-1:0] capture_ff [CAP_N]; // capture a..d values
	frt_pkg::frt_tcr_type tcr_ff; // timer_control_reg
	frt_pkg::frt_compare_output_control_type compare_output_control_ff; // compare_output_control
	logic [4:0] prescale_ff; // system clock divider
	logic ext_clk_prev_ff; // previous count clock pin level
	logic [CAP_N-1:0] pin_prev_ff; // previous capture pin levels
	logic add_fall_next_ff; // auto add: next addition is the fall step
	frt_pkg::frt_mask_state_type mask_ff; // capture d mask state

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire wr = bus_req.wr;
	wire [15:0] wd = bus_req.wdata;
	wire wr_ier = wr && bus_req.addr == frt_pkg::ADDR_INT_ENABLE;
	wire wr_flags = wr && bus_req.addr == frt_pkg::ADDR_EVENT_FLAGS;
	wire wr_cnt = wr && bus_req.addr == frt_pkg::ADDR_COUNTER;
	wire wr_cmp = wr && bus_req.addr == frt_pkg::ADDR_COMPARE;
	wire wr_tcr = wr && bus_req.addr == frt_pkg::ADDR_TIMER_CTRL;
	wire wr_compare_output_control = wr && bus_req.addr == frt_pkg::ADDR_OUT_CTRL;
	// compare a and b sit behind one address
	wire wr_cmp_a = wr_cmp && !compare_output_control_ff.compare_select;
	wire wr_cmp_b = wr_cmp && compare_output_control_ff.compare_select;
	// step and span registers reachable only with capture_select set
	wire wr_rise = wr && compare_output_control_ff.capture_select && bus_req.addr == frt_pkg::ADDR_SHARED_A;
	wire wr_fall = wr && compare_output_control_ff.capture_select && bus_req.addr == frt_pkg::ADDR_SHARED_B;
	wire wr_span = wr && compare_output_control_ff.capture_select && bus_req.addr == frt_pkg::ADDR_SHARED_C;

	// ----------------------------------------------------------------
	// count source
	// ----------------------------------------------------------------
	wire [1:0] cks = {tcr_ff.clock_select_hi, tcr_ff.clock_select_lo};
	// prescale mask per source; external source has no mask
	wire [4:0] pre_mask = (cks == frt_pkg::CKS_DIV2) ? frt_pkg::MASK_DIV2 :
		(cks == frt_pkg::CKS_DIV8) ? frt_pkg::MASK_DIV8 : frt_pkg::MASK_DIV32;
	wire pre_tick = (prescale_ff & pre_mask) == pre_mask;
	wire ext_tick = count_clock_pin && !ext_clk_prev_ff; // rising edge of pin
	wire tick = (cks == frt_pkg::CKS_EXT) ? ext_tick : pre_tick;

	// ----------------------------------------------------------------
	// compare and counter control
	// ----------------------------------------------------------------
	// a match is taken on the count pulse that leaves the equal value
	wire match_a = tick && counter_ff == compare_a_ff;
	wire match_b = tick && counter_ff == compare_b_ff;
	wire clr_a = match_a && clear_on_match_a_ff;
	wire ovf_evt = tick && !clr_a && counter_ff == frt_pkg::COUNT_MAX;
	// counter: bus write wins over counting
	wire [CNT_W-1:0] nxt_counter = wr_cnt ? wd :
		clr_a ? '0 :
		tick ? counter_ff + 1'b1 : counter_ff;
	// auto add of the alternate step to compare a
	wire auto_add = match_a && compare_output_control_ff.auto_add_enable;
	wire [CNT_W-1:0] step_sel = add_fall_next_ff ? fall_step_ff : rise_step_ff;
	wire [CNT_W-1:0] nxt_compare_a = wr_cmp_a ? wd :
		auto_add ? compare_a_ff + step_sel : compare_a_ff;
	// in auto mode the level follows the step last added, not the level bit
	wire level_a = compare_output_control_ff.auto_add_enable ? add_fall_next_ff : compare_output_control_ff.compare_a_pin_level;

	// ----------------------------------------------------------------
	// capture edge detection
	// ----------------------------------------------------------------
	wire [CAP_N-1:0] rise;
	wire [CAP_N-1:0] fall;
	wire [CAP_N-1:0] edge_hit; // single-edge trigger per channel
	wire [CAP_N-1:0] es; // edge select, index 0 = channel a
	genvar gi;
	generate
		for (gi = 0; gi < CAP_N; gi++)
		begin : g_edge
			assign es[gi] = tcr_ff.edge_sel[CAP_N-1-gi];
			assign rise[gi] = capture_pins[gi] && !pin_prev_ff[gi];
			assign fall[gi] = !capture_pins[gi] && pin_prev_ff[gi];
			assign edge_hit[gi] = es[gi] ? rise[gi] : fall[gi];
		end
	endgenerate

	// buffered trigger: same bits give one edge, differing bits give both
	wire buf_a_hit = (es[0] == es[2]) ? edge_hit[0] : (rise[0] || fall[0]);
	wire buf_b_hit = (es[1] == es[3]) ? edge_hit[1] : (rise[1] || fall[1]);
	wire mask_on = mask_ff == frt_pkg::FRT_MASK_ACTIVE;
	// capture events per channel; c and d pins are idle when buffering
	wire [CAP_N-1:0] cap_evt;
	assign cap_evt[0] = tcr_ff.buffer_a_enable ? buf_a_hit : edge_hit[0];
	assign cap_evt[1] = tcr_ff.buffer_b_enable ? buf_b_hit : edge_hit[1];
	assign cap_evt[2] = !tcr_ff.buffer_a_enable && edge_hit[2];
	assign cap_evt[3] = !tcr_ff.buffer_b_enable && edge_hit[3] && !mask_on;

	// ----------------------------------------------------------------
	// capture d mask interval
	// ----------------------------------------------------------------
	wire mask_armed = compare_output_control_ff.capture_d_mask_enable && span_ff != frt_pkg::RST_SPAN;
	wire [CNT_W-1:0] mask_end = capture_ff[3] + {{(CNT_W-9){1'b0}}, span_ff, 1'b0};
	frt_pkg::frt_mask_state_type nxt_mask;
	always_comb
	begin
		nxt_mask = mask_ff;
		unique case (mask_ff)
			frt_pkg::FRT_MASK_IDLE:
			begin
				// a capture d event opens the interval
				if (cap_evt[3] && mask_armed)
					nxt_mask = frt_pkg::FRT_MASK_ACTIVE;
			end
			frt_pkg::FRT_MASK_ACTIVE:
			begin
				// close on end count, or when masking is turned off
				if (!mask_armed || counter_ff == mask_end)
					nxt_mask = frt_pkg::FRT_MASK_IDLE;
			end
			default:
				nxt_mask = frt_pkg::FRT_MASK_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// flags: set beats a write of zero in the same cycle
	// ----------------------------------------------------------------
	// flag bit 7 is channel a, while cap_evt index 0 is channel a
	wire [7:1] flag_set = {cap_evt[0], cap_evt[1], cap_evt[2], cap_evt[3], match_a, match_b, ovf_evt};
	wire [7:1] flag_clr = wr_flags ? ~wd[7:1] : 7'h00;
	wire [7:1] nxt_flags = (flags_ff & ~flag_clr) | flag_set;

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	wire [15:0] rd_cap_or_step_a = compare_output_control_ff.capture_select ? rise_step_ff : capture_ff[0];
	wire [15:0] rd_cap_or_step_b = compare_output_control_ff.capture_select ? fall_step_ff : capture_ff[1];
	wire [15:0] rd_cap_or_span = compare_output_control_ff.capture_select ? {8'h00, span_ff} : capture_ff[2];
	wire [15:0] rd_mux =
		(bus_req.addr == frt_pkg::ADDR_INT_ENABLE) ? {8'h00, int_enable_ff | frt_pkg::IER_FIXED_ONE} :
		(bus_req.addr == frt_pkg::ADDR_EVENT_FLAGS) ? {8'h00, flags_ff, clear_on_match_a_ff} :
		(bus_req.addr == frt_pkg::ADDR_COUNTER) ? counter_ff :
		(bus_req.addr == frt_pkg::ADDR_COMPARE) ?
			(compare_output_control_ff.compare_select ? compare_b_ff : compare_a_ff) :
		(bus_req.addr == frt_pkg::ADDR_TIMER_CTRL) ? {8'h00, tcr_ff} :
		(bus_req.addr == frt_pkg::ADDR_OUT_CTRL) ? {8'h00, compare_output_control_ff} :
		(bus_req.addr == frt_pkg::ADDR_SHARED_A) ? rd_cap_or_step_a :
		(bus_req.addr == frt_pkg::ADDR_SHARED_B) ? rd_cap_or_step_b :
		(bus_req.addr == frt_pkg::ADDR_SHARED_C) ? rd_cap_or_span :
		(bus_req.addr == frt_pkg::ADDR_CAPTURE_D) ? capture_ff[3] : 16'h0000;

	// ----------------------------------------------------------------
	// control and count registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_enable_ff <= frt_pkg::RST_INT_ENABLE;
			flags_ff <= '0;
			clear_on_match_a_ff <= 1'b0;
			counter_ff <= frt_pkg::RST_COUNTER;
			tcr_ff <= frt_pkg::RST_BYTE;
			compare_output_control_ff <= frt_pkg::RST_BYTE;
			prescale_ff <= '0;
			ext_clk_prev_ff <= 1'b0;
			pin_prev_ff <= '0;
			mask_ff <= frt_pkg::FRT_MASK_IDLE;
		end
		else if (ce)
		begin
			if (wr_ier)
				int_enable_ff <= wd[7:0];
			if (wr_flags)
				clear_on_match_a_ff <= wd[frt_pkg::FLAG_CLR_A];
			if (wr_tcr)
				tcr_ff <= wd[7:0];
			if (wr_compare_output_control)
				compare_output_control_ff <= wd[7:0];
			flags_ff <= nxt_flags;
			counter_ff <= nxt_counter;
			prescale_ff <= prescale_ff + 5'h01;
			ext_clk_prev_ff <= count_clock_pin;
			pin_prev_ff <= capture_pins;
			mask_ff <= nxt_mask;
		end
	end

	// ----------------------------------------------------------------
	// compare registers, steps, span and waveform pins
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			compare_a_ff <= frt_pkg::RST_COMPARE;
			compare_b_ff <= frt_pkg::RST_COMPARE;
			rise_step_ff <= frt_pkg::RST_STEP;
			fall_step_ff <= frt_pkg::RST_STEP;
			span_ff <= frt_pkg::RST_SPAN;
			add_fall_next_ff <= 1'b1;
			compare_a_pin_ff <= 1'b0;
			compare_b_pin_ff <= 1'b0;
		end
		else if (ce)
		begin
			compare_a_ff <= nxt_compare_a;
			if (wr_cmp_b)
				compare_b_ff <= wd;
			if (wr_rise)
				rise_step_ff <= wd;
			if (wr_fall)
				fall_step_ff <= wd;
			if (wr_span)
				span_ff <= wd[7:0];
			// first match after enabling adds the fall step
			if (!compare_output_control_ff.auto_add_enable)
				add_fall_next_ff <= 1'b1;
			else if (match_a)
				add_fall_next_ff <= !add_fall_next_ff;
			// pins move only on a match of their own channel
			if (match_a && compare_output_control_ff.compare_a_pin_enable)
				compare_a_pin_ff <= level_a;
			if (match_b && compare_output_control_ff.compare_b_pin_enable)
				compare_b_pin_ff <= compare_output_control_ff.compare_b_pin_level;
		end
	end

	// ----------------------------------------------------------------
	// capture registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < CAP_N; i++)
				capture_ff[i] <= frt_pkg::RST_CAPTURE;
		end
		else if (ce)
		begin
			// loads happen whatever the flag holds
			if (cap_evt[0])
				capture_ff[0] <= counter_ff;
			if (cap_evt[1])
				capture_ff[1] <= counter_ff;
			// buffer takes the old value of its partner in the same edge
			if (tcr_ff.buffer_a_enable ? cap_evt[0] : cap_evt[2])
				capture_ff[2] <= tcr_ff.buffer_a_enable ? capture_ff[0] : counter_ff;
			if (tcr_ff.buffer_b_enable ? cap_evt[1] : cap_evt[3])
				capture_ff[3] <= tcr_ff.buffer_b_enable ? capture_ff[1] : counter_ff;
		end
	end

	// ----------------------------------------------------------------
	// read data and interrupt requests
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			bus_rdata_ff <= 16'h0000;
			irq_req_ff <= 7'h00;
		end
		else if (ce)
		begin
			// read data stands only in the cycle after the strobe
			bus_rdata_ff <= bus_req.rd ? rd_mux : 16'h0000;
			// order: cap a, cap b, cap c, cap d, cmp a, cmp b, overflow
			irq_req_ff <= flags_ff & int_enable_ff[7:1];
		end
	end

endmodule

// *** test/frt_timer_checker.sv ***
// port-level timing checks for the free-running timer
`timescale 1ns/1ps

module frt_timer_checker #(
	parameter int CNT_W = 16, // counter width of the bound design
	parameter int CAP_N = 4 // capture channels of the bound design
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire frt_pkg::frt_bus_req_type bus_req,
	input wire logic [15:0] bus_rdata_ff,
	input wire logic count_clock_pin,
	input wire logic [CAP_N-1:0] capture_pins,
	input wire logic compare_a_pin_ff,
	input wire logic compare_b_pin_ff,
	input wire logic [6:0] irq_req_ff
);
	// ----------------------------------------------------------------
	// assertions, all on the one clock
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_pins_reset_low: assert property (rst_b && !$past(rst_b) |->
		!compare_a_pin_ff && !compare_b_pin_ff) else $error("compare pin high after reset");
	a_irq_reset_low: assert property (rst_b && !$past(rst_b) |->
		irq_req_ff == 7'h00) else $error("request high after reset");
	a_rdata_idle: assert property (ce && !bus_req.rd |=>
		bus_rdata_ff == 16'h0000) else $error("read data outside read slot");
	a_unmapped_zero: assert property (ce && bus_req.rd &&
		(bus_req.addr < 16'hFF90 || bus_req.addr > 16'hFF9F) |=> bus_rdata_ff == 16'h0000)
		else $error("unmapped read not zero");
	a_ier_fixed_one: assert property (ce && bus_req.rd && bus_req.addr == 16'hFF90 |=>
		bus_rdata_ff[0] && bus_rdata_ff[15:8] == 8'h00) else $error("enable bit 0 not one");
	a_byte_upper_zero: assert property (ce && bus_req.rd &&
		bus_req.addr inside {16'hFF91, 16'hFF96, 16'hFF97} |=> bus_rdata_ff[15:8] == 8'h00)
		else $error("byte register upper half not zero");
	a_irq_masked: assert property (ce && bus_req.wr && bus_req.addr == 16'hFF90 &&
		bus_req.wdata[7:1] == 7'h00 ##1 ce |=> irq_req_ff == 7'h00) else $error("masked request");
	a_ce_freeze: assert property (!ce |=> $stable(bus_rdata_ff) && $stable(irq_req_ff) &&
		$stable(compare_a_pin_ff) && $stable(compare_b_pin_ff)) else $error("output moved");
endmodule

bind frt_timer frt_timer_checker #(.CNT_W(CNT_W), .CAP_N(CAP_N)) u_chk (.clk(clk),
	.rst_b(rst_b), .ce(ce), .bus_req(bus_req), .bus_rdata_ff(bus_rdata_ff),
	.count_clock_pin(count_clock_pin), .capture_pins(capture_pins),
	.compare_a_pin_ff(compare_a_pin_ff), .compare_b_pin_ff(compare_b_pin_ff),
	.irq_req_ff(irq_req_ff));

// *** test/frt_pin_source.sv ***
// pin-side model: capture signal sources and external count clock
`timescale 1ns/1ps

module frt_pin_source (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] cap_level, // requested capture pin levels
	input wire logic ext_run, // run the external count clock
	output logic [3:0] capture_pins_ff,
	output logic count_clock_pin_ff
);
	logic [1:0] div_ff; // count clock phase
	logic [1:0] hold_ff [4]; // cycles a level must still stand

	// count clock stands low outside runs, period of four cycles
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			div_ff <= 2'h0;
			count_clock_pin_ff <= 1'b0;
		end
		else
		begin
			div_ff <= ext_run ? div_ff + 2'h1 : 2'h0;
			count_clock_pin_ff <= ext_run & div_ff[1];
		end
	end

	// a level stands four cycles before it may change again
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			capture_pins_ff <= 4'h0;
			hold_ff <= '{default: 2'h0};
		end
		else
		begin
			for (int i = 0; i < 4; i++)
			begin
				if (hold_ff[i] != 2'h0)
					hold_ff[i] <= hold_ff[i] - 2'h1;
				else if (cap_level[i] != capture_pins_ff[i])
				begin
					capture_pins_ff[i] <= cap_level[i];
					hold_ff[i] <= 2'h3;
				end
			end
		end
	end
endmodule

// *** test/tb_frt_timer.sv ***
// self-checking bench for the free-running timer
`timescale 1ns/1ps

module tb_frt_timer;
	logic clk = 1'b0;
	logic rst_b = 1'b0; // active low reset
	logic ce = 1'b1;
	frt_pkg::frt_bus_req_type bus_req = '0;
	logic [3:0] cap_level = 4'h0; // levels asked of the pin model
	logic ext_run = 1'b0; // external count clock runs
	wire logic [15:0] rdata;
	wire logic ext_pin;
	wire logic [3:0] cap_pins;
	wire logic pin_a;
	wire logic pin_b;
	wire logic [6:0] irq;
	int mismatches = 0;
	int cmp_count = 0;
	logic [15:0] rd_val;
	// compare a after each auto add: fall 5, rise 3, fall 5 from 0x0010
	logic [15:0] add_exp [3] = '{16'h0015, 16'h0018, 16'h001D};
	// rows: address, value read after reset
	logic [31:0] rows [10] = '{32'hFF90_0001, 32'hFF91_0000, 32'hFF94_FFFF, 32'hFF96_0000,
		32'hFF97_0000, 32'hFF98_0000, 32'hFF9A_0000, 32'hFF9C_0000, 32'hFF9E_0000, 32'hFFA0_0000};

	always #20 clk = ~clk;

	frt_timer dut (.clk(clk), .rst_b(rst_b), .ce(ce), .bus_req(bus_req), .bus_rdata_ff(rdata),
		.count_clock_pin(ext_pin), .capture_pins(cap_pins), .compare_a_pin_ff(pin_a),
		.compare_b_pin_ff(pin_b), .irq_req_ff(irq));
	frt_pin_source u_src (.clk(clk), .rst_b(rst_b), .cap_level(cap_level), .ext_run(ext_run),
		.capture_pins_ff(cap_pins), .count_clock_pin_ff(ext_pin));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one-cycle write strobe
	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus_req.wr <= 1'b0;
	endtask

	// one-cycle read strobe, data taken in the following cycle
	task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus_req.rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
		bus_rd(a, rd_val);
		check("register", rd_val, exp);
	endtask

	// bounded poll of one flag bit
	task automatic wait_flag(input int b);
		for (int i = 0; i < 200; i++)
		begin
			bus_rd(16'hFF91, rd_val);
			if (rd_val[b] === 1'b1)
				return;
		end
		mismatches++;
		complete_run();
	endtask

	task automatic reset_rows;
		foreach (rows[i])
		begin
			bus_rd(rows[i][31:16], rd_val);
			check("reset value", rd_val, rows[i][15:0]);
		end
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		reset_rows();
		// shared addresses, counter stopped on idle external clock
		bus_wr(16'hFF96, 16'h0003);
		bus_wr(16'hFF94, 16'h1234);
		bus_wr(16'hFF97, 16'h0010);
		bus_wr(16'hFF94, 16'h5678);
		rd_chk(16'hFF94, 16'h5678);
		bus_wr(16'hFF97, 16'h0000);
		rd_chk(16'hFF94, 16'h1234);
		bus_wr(16'hFF97, 16'h0020);
		rd_chk(16'hFF98, 16'hFFFF);
		bus_wr(16'hFF9C, 16'h1240);
		rd_chk(16'hFF9C, 16'h0040);
		// compare a with pin a driven high, then wrap
		bus_wr(16'hFF97, 16'h000A);
		bus_wr(16'hFF94, 16'hFFFE);
		bus_wr(16'hFF92, 16'hFFFD);
		bus_wr(16'hFF91, 16'h0000);
		rd_chk(16'hFF92, 16'hFFFD);
		check("pin a", {15'h0, pin_a}, 16'h0000);
		ext_run <= 1'b1;
		wait_flag(1);
		ext_run <= 1'b0;
		rd_chk(16'hFF91, 16'h000A);
		check("pin a", {15'h0, pin_a}, 16'h0001);
		check("pin b", {15'h0, pin_b}, 16'h0000);
		bus_wr(16'hFF91, 16'h00FF);
		rd_chk(16'hFF91, 16'h000B);
		bus_wr(16'hFF91, 16'h0001);
		rd_chk(16'hFF91, 16'h0001);
		// clear on match a
		bus_wr(16'hFF92, 16'h0010);
		bus_wr(16'hFF94, 16'h0011);
		ext_run <= 1'b1;
		wait_flag(3);
		ext_run <= 1'b0;
		bus_rd(16'hFF92, rd_val);
		check("counter cleared", {15'h0, rd_val < 16'h0011}, 16'h0001);
		// captures on rising edges
		bus_wr(16'hFF91, 16'h0000);
		bus_wr(16'hFF97, 16'h0000);
		bus_wr(16'hFF96, 16'h00F3);
		bus_wr(16'hFF92, 16'h0100);
		cap_level <= 4'hF;
		repeat (6) @(posedge clk);
		for (int ch = 0; ch < 4; ch++)
			rd_chk(16'hFF98 + 16'(2 * ch), 16'h0100);
		rd_chk(16'hFF91, 16'h00F0);
		bus_wr(16'hFF92, 16'h0200);
		cap_level <= 4'h0;
		repeat (6) @(posedge clk);
		rd_chk(16'hFF98, 16'h0100);
		bus_wr(16'hFF92, 16'h0300);
		cap_level <= 4'hF;
		repeat (6) @(posedge clk);
		rd_chk(16'hFF98, 16'h0300);
		// buffered a on both edges
		bus_wr(16'hFF96, 16'h008B);
		bus_wr(16'hFF91, 16'h0000);
		bus_wr(16'hFF92, 16'h0400);
		cap_level <= 4'h0;
		repeat (6) @(posedge clk);
		rd_chk(16'hFF98, 16'h0400);
		rd_chk(16'hFF9C, 16'h0300);
		// a, b and d flags only: pin c is ignored while it buffers a
		rd_chk(16'hFF91, 16'h00D0);
		// requests follow flags and enables
		bus_wr(16'hFF90, 16'h00FF);
		@(posedge clk);
		#1 check("requests", {9'h0, irq}, 16'h0068);
		bus_wr(16'hFF90, 16'h00A0);
		@(posedge clk);
		#1 check("requests", {9'h0, irq}, 16'h0040);
		bus_wr(16'hFF91, 16'h0000);
		@(posedge clk);
		#1 check("requests", {9'h0, irq}, 16'h0000);
		bus_wr(16'hFF90, 16'h0001);
		// auto add: level bit a is 0, but pin a shows the step order
		bus_wr(16'hFF97, 16'h0020);
		bus_wr(16'hFF98, 16'h0003);
		bus_wr(16'hFF9A, 16'h0005);
		bus_wr(16'hFF97, 16'h0048);
		bus_wr(16'hFF94, 16'h0010);
		bus_wr(16'hFF92, 16'h000F);
		for (int m = 0; m < 3; m++)
		begin
			bus_wr(16'hFF91, 16'h0000);
			ext_run <= 1'b1;
			wait_flag(3);
			ext_run <= 1'b0;
			rd_chk(16'hFF94, add_exp[m]);
			check("pin a auto", {15'h0, pin_a}, {15'h0, m != 1});
		end
		// capture d mask of twice span 4, pin b armed on compare b
		bus_wr(16'hFF97, 16'h0030);
		bus_wr(16'hFF9C, 16'h0004);
		bus_wr(16'hFF94, 16'h0010);
		bus_wr(16'hFF97, 16'h0085);
		bus_wr(16'hFF96, 16'h0013);
		bus_wr(16'hFF92, 16'h0100);
		cap_level <= 4'h8;
		repeat (6) @(posedge clk);
		cap_level <= 4'h0;
		bus_wr(16'hFF92, 16'h0200);
		cap_level <= 4'h8;
		repeat (6) @(posedge clk);
		rd_chk(16'hFF9E, 16'h0100);
		bus_wr(16'hFF92, 16'h0108);
		cap_level <= 4'h0;
		repeat (6) @(posedge clk);
		cap_level <= 4'h8;
		repeat (6) @(posedge clk);
		rd_chk(16'hFF9E, 16'h0108);
		// prescale: 64 edges give 64 / divisor counts, whatever the phase
		for (int k = 0; k < 3; k++)
		begin
			bus_wr(16'hFF96, 16'(k));
			bus_wr(16'hFF92, 16'h0000);
			repeat (63) @(posedge clk);
			rd_chk(16'hFF92, 16'(64 >> (2 * k + 1)));
		end
		check("pin b", {15'h0, pin_b}, 16'h0001);
		// clock enable low freezes outputs
		ce <= 1'b0;
		repeat (4) @(posedge clk);
		ce <= 1'b1;
		// second reset mid-run
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		check("pin a", {15'h0, pin_a}, 16'h0000);
		check("pin b", {15'h0, pin_b}, 16'h0000);
		rst_b <= 1'b1;
		reset_rows();
		complete_run();
	end
endmodule
